// ---- ata_task_file_registers.sv ----
`timescale 1ns/1ps
`default_nettype none
module ata_task_file_registers
  import task_file_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Host register port
  input wire logic host_read_in,
  input wire logic host_write_in,
  input wire logic [3:0] offset_in,
  input wire logic upper_byte_enable_n_in,
  input wire logic lower_byte_enable_n_in,
  input wire logic [15:0] wdata_in,
  output logic [15:0] rdata_out,
  // Card configuration
  input wire logic card_copy_in,
  // Command core status
  input wire logic core_ready_in,
  input wire logic write_fault_flag_in,
  input wire logic device_settled_flag_in,
  input wire logic transfer_request_flag_in,
  input wire logic corrected_error_flag_in,
  input wire logic sector_done_in,
  input wire logic cmd_done_in,
  input wire logic cmd_ok_in,
  input wire logic [7:0] error_flags_in,
  input wire logic irq_event_in,
  // Command core control
  output logic cmd_write_out,
  output logic [7:0] cmd_code_out,
  output logic [7:0] feature_out,
  output logic [8:0] transfer_length_out,
  output logic lba_mode_out,
  output logic [27:0] address_out,
  output logic drive_selected_out,
  output logic soft_reset_out,
  output logic irq_out,
  output logic config_irq_bit_out
);

  // ------------------------------------------------------------------
  // Access decode
  // ------------------------------------------------------------------
  logic [3:0] reg_offset;
  logic [7:0] byte_data;
  logic upper_lane;
  logic lane_valid;

  task_file_lane_decode lane_decode (
    .offset_in(offset_in),
    .upper_byte_enable_n_in(upper_byte_enable_n_in),
    .lower_byte_enable_n_in(lower_byte_enable_n_in),
    .wdata_in(wdata_in),
    .reg_offset_out(reg_offset),
    .byte_data_out(byte_data),
    .upper_lane_out(upper_lane),
    .valid_out(lane_valid)
  );

  logic [7:0] feature_reg;
  logic [7:0] count_reg;
  logic [7:0] sector_reg;
  logic [7:0] cyl_low_reg;
  logic [7:0] cyl_high_reg;
  logic [7:0] drive_head_reg;
  logic [7:0] error_reg;
  logic busy_reg;
  logic ready_reg;
  logic irq_disable_reg;
  logic soft_reset_reg;
  logic irq_pending_reg;
  srst_state_t srst_state_reg;
  srst_state_t srst_state_next;
  logic [7:0] status_value;
  logic wr;
  logic rd;
  logic addr_wr;
  logic restore;

  assign wr = host_write_in && lane_valid;
  assign rd = host_read_in && lane_valid;
  // Busy blocks host writes to the command block; the control register
  // stays writable so a soft reset can always be issued.
  assign addr_wr = wr && !busy_reg;
  assign restore = (srst_state_reg == ST_SRST);

  // ------------------------------------------------------------------
  // Soft reset sequencing
  // ------------------------------------------------------------------
  always_comb begin
    srst_state_next = srst_state_reg;
    unique case (srst_state_reg)
      ST_RUN: begin
        if (soft_reset_reg) begin
          srst_state_next = ST_SRST;
        end
      end
      ST_SRST: begin
        if (!soft_reset_reg) begin
          srst_state_next = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        srst_state_next = soft_reset_reg ? ST_SRST : ST_RUN;
      end
      default: begin
        srst_state_next = ST_SRST;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      srst_state_reg <= ST_RUN;
    end else begin
      srst_state_reg <= srst_state_next;
    end
  end

  // ------------------------------------------------------------------
  // Device control
  // ------------------------------------------------------------------
  // Only the soft reset and interrupt disable bits are kept; the rest
  // of the written byte is dropped.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      soft_reset_reg <= 1'b0;
      irq_disable_reg <= RST_IRQ_DIS;
    end else if (wr && reg_offset == OFS_SHADOW_CTRL) begin
      soft_reset_reg <= byte_data[CTL_SRST_POS];
      irq_disable_reg <= byte_data[CTL_IRQ_DIS_POS];
    end
  end

  // ------------------------------------------------------------------
  // Feature and addressing registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      feature_reg <= RST_FEATURE;
    end else if (restore) begin
      feature_reg <= RST_FEATURE;
    end else if (addr_wr && (reg_offset == OFS_FEATURE || reg_offset == OFS_FEATURE_DUP)) begin
      feature_reg <= byte_data;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      sector_reg <= RST_SECTOR;
      cyl_low_reg <= RST_CYL;
      cyl_high_reg <= RST_CYL;
      drive_head_reg <= RST_DRIVE_HEAD;
    end else if (restore) begin
      sector_reg <= RST_SECTOR;
      cyl_low_reg <= RST_CYL;
      cyl_high_reg <= RST_CYL;
      drive_head_reg <= RST_DRIVE_HEAD;
    end else if (addr_wr) begin
      if (reg_offset == OFS_SECTOR) begin
        sector_reg <= byte_data;
      end
      if (reg_offset == OFS_CYL_LOW) begin
        cyl_low_reg <= byte_data;
      end
      if (reg_offset == OFS_CYL_HIGH) begin
        cyl_high_reg <= byte_data;
      end
      if (reg_offset == OFS_DRIVE_HEAD) begin
        drive_head_reg <= byte_data;
        drive_head_reg[DH_ONE_HI_POS] <= 1'b1;
        drive_head_reg[DH_ONE_LO_POS] <= 1'b1;
      end
    end
  end

  // The core reports completion; the count tracks sectors still owed.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      count_reg <= RST_COUNT;
    end else if (restore) begin
      count_reg <= RST_COUNT;
    end else if (cmd_done_in && cmd_ok_in) begin
      count_reg <= 8'h00;
    end else if (sector_done_in) begin
      count_reg <= count_reg - 8'h01;
    end else if (addr_wr && reg_offset == OFS_COUNT) begin
      count_reg <= byte_data;
    end
  end

  // ------------------------------------------------------------------
  // Error capture
  // ------------------------------------------------------------------
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      error_reg <= 8'h00;
    end else if (restore) begin
      error_reg <= 8'h00;
    end else if (cmd_done_in) begin
      error_reg <= cmd_ok_in ? 8'h00 : (error_flags_in & ERR_USED_MASK);
    end
  end

  // ------------------------------------------------------------------
  // Busy, ready and interrupt
  // ------------------------------------------------------------------
  // Busy rises on the edge that takes the command, well inside the
  // allowed BUSY_SET_CYCLES, so the host never sees a stale clear.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      busy_reg <= 1'b0;
    end else if (soft_reset_reg || restore) begin
      busy_reg <= 1'b1;
    end else if (srst_state_reg == ST_RECOVER) begin
      busy_reg <= 1'b0;
    end else if (addr_wr && reg_offset == OFS_STATE) begin
      busy_reg <= 1'b1;
    end else if (cmd_done_in) begin
      busy_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= core_ready_in && !soft_reset_reg;
    end
  end

  // A new event wins over a clearing status read in the same cycle.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      irq_pending_reg <= 1'b0;
    end else if (irq_event_in) begin
      irq_pending_reg <= 1'b1;
    end else if (restore || (rd && reg_offset == OFS_STATE)) begin
      irq_pending_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Status composition
  // ------------------------------------------------------------------
  // While busy only the busy bit is reported, so the host cannot act on
  // half-updated flags.
  always_comb begin
    status_value = 8'h00;
    if (busy_reg) begin
      status_value[ST_BUSY_POS] = 1'b1;
    end else begin
      status_value[ST_READY_POS] = ready_reg;
      status_value[ST_FAULT_POS] = write_fault_flag_in;
      status_value[ST_SETTLED_POS] = device_settled_flag_in;
      status_value[ST_XFER_POS] = transfer_request_flag_in;
      status_value[ST_CORRECTED_ERROR_FLAG_POS] = corrected_error_flag_in;
      status_value[ST_ERR_POS] = (error_reg != 8'h00);
    end
  end

  // ------------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------------
  // The data register and unused offsets read as zero here; feature reads error, control reads status.
  logic [7:0] read_value;

  always_comb begin
    read_value = 8'h00;
    unique case (reg_offset)
      OFS_FEATURE: read_value = error_reg;
      OFS_FEATURE_DUP: read_value = error_reg;
      OFS_COUNT: read_value = count_reg;
      OFS_SECTOR: read_value = sector_reg;
      OFS_CYL_LOW: read_value = cyl_low_reg;
      OFS_CYL_HIGH: read_value = cyl_high_reg;
      OFS_DRIVE_HEAD: read_value = drive_head_reg;
      OFS_STATE: read_value = status_value;
      OFS_SHADOW_CTRL: read_value = status_value;
      default: read_value = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_out <= 16'h0000;
    end else if (rd) begin
      rdata_out <= upper_lane ? {read_value, 8'h00} : {8'h00, read_value};
    end
  end

  // ------------------------------------------------------------------
  // Core-facing outputs
  // ------------------------------------------------------------------
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      cmd_write_out <= 1'b0;
      cmd_code_out <= 8'h00;
    end else begin
      cmd_write_out <= addr_wr && reg_offset == OFS_STATE;
      if (addr_wr && reg_offset == OFS_STATE) begin
        cmd_code_out <= byte_data;
      end
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      feature_out <= RST_FEATURE;
      transfer_length_out <= {1'b0, RST_COUNT};
      lba_mode_out <= 1'b0;
      address_out <= 28'h0000000;
      drive_selected_out <= 1'b0;
    end else begin
      feature_out <= feature_reg;
      transfer_length_out <= (count_reg == 8'h00) ? FULL_TRANSFER : {1'b0, count_reg};
      lba_mode_out <= drive_head_reg[DH_LBA_POS];
      address_out <= {drive_head_reg[3:0], cyl_high_reg, cyl_low_reg, sector_reg};
      drive_selected_out <= (drive_head_reg[DH_DRIVE_POS] == card_copy_in);
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      soft_reset_out <= 1'b0;
      irq_out <= 1'b0;
      config_irq_bit_out <= RST_IRQ_DIS;
    end else begin
      soft_reset_out <= soft_reset_reg;
      irq_out <= irq_pending_reg && !irq_disable_reg;
      config_irq_bit_out <= irq_disable_reg;
    end
  end

endmodule
`default_nettype wire

// ---- task_file_pkg.sv ----
package task_file_pkg;

  // ------------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------------
  localparam logic [3:0] OFS_FEATURE = 4'h1;
  localparam logic [3:0] OFS_COUNT = 4'h2;
  localparam logic [3:0] OFS_SECTOR = 4'h3;
  localparam logic [3:0] OFS_CYL_LOW = 4'h4;
  localparam logic [3:0] OFS_CYL_HIGH = 4'h5;
  localparam logic [3:0] OFS_DRIVE_HEAD = 4'h6;
  localparam logic [3:0] OFS_STATE = 4'h7;
  localparam logic [3:0] OFS_FEATURE_DUP = 4'hd;
  localparam logic [3:0] OFS_SHADOW_CTRL = 4'he;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int DH_ONE_HI_POS = 7;
  localparam int DH_LBA_POS = 6;
  localparam int DH_ONE_LO_POS = 5;
  localparam int DH_DRIVE_POS = 4;
  localparam int ST_BUSY_POS = 7;
  localparam int ST_READY_POS = 6;
  localparam int ST_FAULT_POS = 5;
  localparam int ST_SETTLED_POS = 4;
  localparam int ST_XFER_POS = 3;
  localparam int ST_CORRECTED_ERROR_FLAG_POS = 2;
  localparam int ST_ERR_POS = 0;
  localparam int CTL_SRST_POS = 2;
  localparam int CTL_IRQ_DIS_POS = 1;
  // Error register bits that carry flags; 5, 3 and 1 always read zero.
  localparam logic [7:0] ERR_USED_MASK = 8'hd5;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] RST_FEATURE = 8'h00;
  localparam logic [7:0] RST_COUNT = 8'h01;
  localparam logic [7:0] RST_SECTOR = 8'h01;
  localparam logic [7:0] RST_CYL = 8'h00;
  localparam logic [7:0] RST_DRIVE_HEAD = 8'ha0;
  localparam logic RST_IRQ_DIS = 1'b1;
  localparam logic [8:0] FULL_TRANSFER = 9'h100;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int BUSY_SET_MAX_NS = 400;
  localparam int BUSY_SET_CYCLES = (BUSY_SET_MAX_NS / CLK_PERIOD_NS < 1) ? 1 :
                                   BUSY_SET_MAX_NS / CLK_PERIOD_NS;

  // ------------------------------------------------------------------
  // Soft reset sequencing
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_SRST = 2'b01,
    ST_RECOVER = 2'b10
  } srst_state_t;

endpackage

// ---- task_file_lane_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
module task_file_lane_decode
  import task_file_pkg::*;
(
  // Host access qualifiers
  input wire logic [3:0] offset_in,
  input wire logic upper_byte_enable_n_in,
  input wire logic lower_byte_enable_n_in,
  input wire logic [15:0] wdata_in,
  // Decoded access
  output logic [3:0] reg_offset_out,
  output logic [7:0] byte_data_out,
  output logic upper_lane_out,
  output logic valid_out
);

  // ------------------------------------------------------------------
  // Lane steering
  // ------------------------------------------------------------------
  // An upper-only access reaches the odd register one above the even
  // address on D15-D8. A word access to the duplicate feature offset
  // also uses the upper lane; other word accesses target the data
  // register, which is not part of this block.
  always_comb begin
    reg_offset_out = offset_in;
    byte_data_out = wdata_in[7:0];
    upper_lane_out = 1'b0;
    valid_out = 1'b0;
    if (upper_byte_enable_n_in && !lower_byte_enable_n_in) begin
      valid_out = 1'b1;
    end else if (!upper_byte_enable_n_in && lower_byte_enable_n_in) begin
      reg_offset_out = {offset_in[3:1], 1'b1};
      byte_data_out = wdata_in[15:8];
      upper_lane_out = 1'b1;
      valid_out = 1'b1;
    end else if (!upper_byte_enable_n_in && !lower_byte_enable_n_in) begin
      if (offset_in == OFS_FEATURE_DUP) begin
        byte_data_out = wdata_in[15:8];
        upper_lane_out = 1'b1;
        valid_out = 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ---- ata_task_file_checker_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module ata_task_file_checker
  import task_file_pkg::*;
(
  // Clock, reset and host port
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic host_read_in,
  input wire logic host_write_in,
  input wire logic [3:0] offset_in,
  input wire logic upper_byte_enable_n_in,
  input wire logic lower_byte_enable_n_in,
  input wire logic [15:0] wdata_in,
  input wire logic [15:0] rdata_out,
  input wire logic card_copy_in,
  // Core side outputs
  input wire logic cmd_write_out,
  input wire logic [8:0] transfer_length_out,
  input wire logic lba_mode_out,
  input wire logic [27:0] address_out,
  input wire logic drive_selected_out,
  input wire logic soft_reset_out,
  input wire logic irq_out,
  input wire logic config_irq_bit_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  logic rd_low;
  logic wr_low;
  assign rd_low = host_read_in && !lower_byte_enable_n_in && upper_byte_enable_n_in;
  assign wr_low = host_write_in && !lower_byte_enable_n_in && upper_byte_enable_n_in;

  // An upper-only byte write at offset 6 also reaches the command slot.
  cmd_pulse_a: assert property (cmd_write_out |->
      $past(host_write_in) && $past(offset_in[3:1]) == OFS_STATE[3:1])
    else $error("command pulse without a command write");
  sector_field_a: assert property (rd_low && offset_in == OFS_SECTOR |=>
      address_out[7:0] == rdata_out[7:0])
    else $error("sector field differs from register");
  cyl_low_field_a: assert property (rd_low && offset_in == OFS_CYL_LOW |=>
      address_out[15:8] == rdata_out[7:0])
    else $error("cylinder low field differs from register");
  cyl_high_field_a: assert property (rd_low && offset_in == OFS_CYL_HIGH |=>
      address_out[23:16] == rdata_out[7:0])
    else $error("cylinder high field differs from register");
  head_field_a: assert property (rd_low && offset_in == OFS_DRIVE_HEAD |=>
      address_out[27:24] == rdata_out[3:0])
    else $error("head field differs from register");
  mode_select_a: assert property (rd_low && offset_in == OFS_DRIVE_HEAD |=>
      lba_mode_out == rdata_out[6] &&
      drive_selected_out == (rdata_out[4] == $past(card_copy_in)))
    else $error("mode or drive select differs from register");
  fixed_ones_a: assert property (rd_low && offset_in == OFS_DRIVE_HEAD |=>
      rdata_out[7] && rdata_out[5])
    else $error("drive head fixed bits not one");
  state_zero_a: assert property (rd_low && offset_in == OFS_STATE |=>
      rdata_out[15:8] == 8'h00 && !rdata_out[1])
    else $error("status reserved bit not zero");
  busy_srst_a: assert property (rd_low && offset_in == OFS_STATE && soft_reset_out &&
      $past(soft_reset_out) |=> rdata_out == 16'h0080)
    else $error("status not busy during soft reset");
  srst_follow_a: assert property (wr_low && offset_in == OFS_SHADOW_CTRL |->
      ##2 soft_reset_out == $past(wdata_in[2], 2))
    else $error("soft reset does not follow control bit");
  irq_ctl_follow_a: assert property (wr_low && offset_in == OFS_SHADOW_CTRL |->
      ##2 config_irq_bit_out == $past(wdata_in[1], 2))
    else $error("interrupt disable does not follow control bit");
  irq_masked_a: assert property (irq_out |-> !config_irq_bit_out)
    else $error("interrupt raised while disabled");
  length_range_a: assert property (transfer_length_out != 9'h000 &&
      transfer_length_out <= FULL_TRANSFER)
    else $error("transfer length out of range");
endmodule

bind ata_task_file_registers ata_task_file_checker u_chk (
  .clk_in(clk_in), .reset_in(reset_in), .host_read_in(host_read_in),
  .host_write_in(host_write_in), .offset_in(offset_in),
  .upper_byte_enable_n_in(upper_byte_enable_n_in),
  .lower_byte_enable_n_in(lower_byte_enable_n_in), .wdata_in(wdata_in),
  .rdata_out(rdata_out), .card_copy_in(card_copy_in), .cmd_write_out(cmd_write_out),
  .transfer_length_out(transfer_length_out), .lba_mode_out(lba_mode_out),
  .address_out(address_out), .drive_selected_out(drive_selected_out),
  .soft_reset_out(soft_reset_out), .irq_out(irq_out),
  .config_irq_bit_out(config_irq_bit_out)
);
`default_nettype wire

// ---- host_port_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_port_model
  import task_file_pkg::*;
(
  // Clock and read data
  input wire logic clk_in,
  input wire logic [15:0] rdata_in,
  // Register port strobes
  output logic host_read_out,
  output logic host_write_out,
  output logic [3:0] offset_out,
  output logic upper_byte_enable_n_out,
  output logic lower_byte_enable_n_out,
  output logic [15:0] wdata_out
);
  initial begin
    host_read_out = 1'b0;
    host_write_out = 1'b0;
    offset_out = 4'h0;
    {upper_byte_enable_n_out, lower_byte_enable_n_out} = 2'b11;
    wdata_out = 16'h0000;
  end

  // Released data shows the inverse so a stale value is never mistaken for a hold.
  task automatic wr(input logic [3:0] ofs, input logic [15:0] d, input logic [1:0] lanes_n);
    logic [15:0] v;
    v = d;
    if (ofs == OFS_DRIVE_HEAD) v = v | 16'h00a0;
    @(posedge clk_in);
    host_write_out <= 1'b1;
    offset_out <= ofs;
    {upper_byte_enable_n_out, lower_byte_enable_n_out} <= lanes_n;
    wdata_out <= v;
    @(posedge clk_in);
    host_write_out <= 1'b0;
    {upper_byte_enable_n_out, lower_byte_enable_n_out} <= 2'b11;
    wdata_out <= ~v;
  endtask

  task automatic rd(input logic [3:0] ofs, output logic [15:0] d);
    @(posedge clk_in);
    host_read_out <= 1'b1;
    offset_out <= ofs;
    {upper_byte_enable_n_out, lower_byte_enable_n_out} <= 2'b10;
    @(posedge clk_in);
    host_read_out <= 1'b0;
    {upper_byte_enable_n_out, lower_byte_enable_n_out} <= 2'b11;
    @(posedge clk_in);
    #1 d = rdata_in;
  endtask

  // Commands go out once the shadow copy shows busy clear, or after 64 polls if it never does.
  // A poll that runs out is reported through stuck so the bench can count it.
  task automatic cmd(input logic [7:0] code, output logic stuck);
    logic [15:0] s;
    int n;
    s = 16'h0080;
    n = 0;
    while (s[7] && n < 64) begin
      rd(OFS_SHADOW_CTRL, s);
      n++;
    end
    stuck = s[7];
    wr(OFS_STATE, {8'h00, code}, 2'b10);
  endtask
endmodule
`default_nettype wire

// ---- ata_task_file_registers_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module ata_task_file_registers_tb_top
  import task_file_pkg::*;
;
  typedef struct packed {logic [3:0] ofs; logic [7:0] wv; logic [7:0] exp;} row_t;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic rd_s, wr_s, ue_n, le_n, card_copy = 1'b0, ready = 1'b0, fault = 1'b0;
  logic settled = 1'b0, xfer = 1'b0, corrected_error_flag = 1'b0, sdone = 1'b0, done = 1'b0;
  logic ok = 1'b0, irq_ev = 1'b0, cmd_w, lba, drv, srst, irq, cfg_irq, tmo;
  logic [3:0] ofs;
  logic [7:0] eflags = 8'h00, code, feat;
  logic [8:0] tlen;
  logic [15:0] wdata, rdata, rv;
  logic [27:0] addr;
  int errors = 0;
  int tests_run = 0;
  int seen;
  row_t rows[6] = '{'{OFS_SECTOR, 8'h5a, 8'h5a}, '{OFS_CYL_LOW, 8'hc3, 8'hc3},
    '{OFS_CYL_HIGH, 8'h3c, 8'h3c}, '{OFS_DRIVE_HEAD, 8'h49, 8'he9},
    '{OFS_FEATURE, 8'h77, 8'h00}, '{OFS_COUNT, 8'h00, 8'h00}};

  always #25 clk_in = ~clk_in;

  host_port_model u_host (.clk_in(clk_in), .rdata_in(rdata), .host_read_out(rd_s),
    .host_write_out(wr_s), .offset_out(ofs), .upper_byte_enable_n_out(ue_n),
    .lower_byte_enable_n_out(le_n), .wdata_out(wdata));

  ata_task_file_registers u_dut (.clk_in(clk_in), .reset_in(reset_in), .host_read_in(rd_s),
    .host_write_in(wr_s), .offset_in(ofs), .upper_byte_enable_n_in(ue_n),
    .lower_byte_enable_n_in(le_n), .wdata_in(wdata), .rdata_out(rdata),
    .card_copy_in(card_copy), .core_ready_in(ready), .write_fault_flag_in(fault),
    .device_settled_flag_in(settled), .transfer_request_flag_in(xfer),
    .corrected_error_flag_in(corrected_error_flag), .sector_done_in(sdone), .cmd_done_in(done),
    .cmd_ok_in(ok), .error_flags_in(eflags), .irq_event_in(irq_ev), .cmd_write_out(cmd_w),
    .cmd_code_out(code), .feature_out(feat), .transfer_length_out(tlen), .lba_mode_out(lba),
    .address_out(addr), .drive_selected_out(drv), .soft_reset_out(srst), .irq_out(irq),
    .config_irq_bit_out(cfg_irq));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [3:0] o, input logic [7:0] exp);
    u_host.rd(o, rv);
    check({16'h0, rv}, {24'h0, exp});
  endtask

  task automatic wchk(input logic [3:0] o, input logic [15:0] d, input logic [1:0] l);
    u_host.wr(o, d, l);
    repeat (2) @(posedge clk_in);
  endtask

  task automatic finish_cmd(input logic good, input logic [7:0] f);
    @(posedge clk_in);
    done <= 1'b1;
    ok <= good;
    eflags <= f;
    @(posedge clk_in);
    done <= 1'b0;
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_in);
    errors++;
    conclude();
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_in);
    reset_in <= 1'b0;
    rchk(OFS_COUNT, RST_COUNT);
    rchk(OFS_DRIVE_HEAD, RST_DRIVE_HEAD);
    rchk(OFS_STATE, 8'h00);
    check({31'h0, cfg_irq}, 32'h1);
    foreach (rows[i]) begin
      u_host.wr(rows[i].ofs, {8'h00, rows[i].wv}, 2'b10);
      rchk(rows[i].ofs, rows[i].exp);
    end
    @(posedge clk_in);
    check({23'h0, tlen}, {23'h0, FULL_TRANSFER});
    check({4'h0, addr}, 32'h093cc35a);
    check({feat, lba, drv}, {8'h77, 2'b11});
    card_copy <= 1'b1;
    repeat (2) @(posedge clk_in);
    check({31'h0, drv}, 32'h0);
    wchk(4'h0, 16'h9900, 2'b01);
    check({24'h0, feat}, 32'h99);
    wchk(OFS_FEATURE_DUP, 16'h4400, 2'b00);
    check({24'h0, feat}, 32'h44);
    {ready, fault, settled, xfer, corrected_error_flag} <= 5'b11111;
    repeat (2) @(posedge clk_in);
    rchk(OFS_STATE, 8'h7c);
    rchk(OFS_SHADOW_CTRL, 8'h7c);
    {fault, xfer, corrected_error_flag} <= 3'b000;
    u_host.wr(OFS_COUNT, 16'h0003, 2'b10);
    fork
      u_host.cmd(8'h20, tmo);
      begin
        seen = 0;
        repeat (12) @(posedge clk_in) #1 if (cmd_w === 1'b1) seen++;
      end
    join
    check({31'h0, tmo}, 32'h0);
    check(seen, 1);
    check({24'h0, code}, 32'h20);
    rchk(OFS_STATE, 8'h80);
    @(posedge clk_in);
    sdone <= 1'b1;
    @(posedge clk_in);
    sdone <= 1'b0;
    finish_cmd(1'b0, 8'hff);
    rchk(OFS_COUNT, 8'h02);
    rchk(OFS_STATE, 8'h51);
    rchk(OFS_FEATURE, 8'hd5);
    u_host.cmd(8'h30, tmo);
    check({31'h0, tmo}, 32'h0);
    finish_cmd(1'b1, 8'h00);
    rchk(OFS_COUNT, 8'h00);
    wchk(OFS_SHADOW_CTRL, 16'h0000, 2'b10);
    @(posedge clk_in);
    irq_ev <= 1'b1;
    @(posedge clk_in);
    irq_ev <= 1'b0;
    repeat (2) @(posedge clk_in);
    check({30'h0, irq, cfg_irq}, 32'h2);
    wchk(OFS_SHADOW_CTRL, 16'h0002, 2'b10);
    check({30'h0, irq, cfg_irq}, 32'h1);
    wchk(OFS_SHADOW_CTRL, 16'h0000, 2'b10);
    u_host.rd(OFS_SHADOW_CTRL, rv);
    repeat (2) @(posedge clk_in);
    check({31'h0, irq}, 32'h1);
    u_host.rd(OFS_STATE, rv);
    repeat (2) @(posedge clk_in);
    check({31'h0, irq}, 32'h0);
    wchk(OFS_SHADOW_CTRL, 16'h00f9, 2'b10);
    check({29'h0, irq, cfg_irq, srst}, 32'h0);
    u_host.wr(OFS_SECTOR, 16'h0077, 2'b10);
    wchk(OFS_SHADOW_CTRL, 16'h0004, 2'b10);
    rchk(OFS_STATE, 8'h80);
    rchk(OFS_SECTOR, RST_SECTOR);
    check({31'h0, srst}, 32'h1);
    wchk(OFS_SHADOW_CTRL, 16'h0000, 2'b10);
    repeat (3) @(posedge clk_in);
    rchk(OFS_STATE, 8'h50);
    reset_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    rchk(OFS_COUNT, RST_COUNT);
    conclude();
  end
endmodule
`default_nettype wire
